// ### inc/cmsc_pkg.sv
/*
 * Shared constants for the contact monitor mode controller: command
 * field positions, reset values, times and their cycle counts.
 * Assumes a single 250 MHz clock; long counts are overridable at the top.
 */
package cmsc_pkg;

    // Clock rate and times as specified
    localparam int CLK_MHZ        = 250;
    localparam int MS_IN_US       = 1000;
    localparam int POLL_WINDOW_US = 250;
    localparam int WAKE_DELAY_US  = 200;
    localparam int WET_PULSE_MS   = 20;

    // Cycle counts derived from the times above
    localparam int MS_CYC         = MS_IN_US * CLK_MHZ;
    localparam int POLL_WINDOW_CYC = POLL_WINDOW_US * CLK_MHZ;
    localparam int WAKE_DELAY_CYC = WAKE_DELAY_US * CLK_MHZ;

    // Command register layout and reset value
    localparam logic [15:0] CMD_RESET    = 16'h0000;
    localparam int          CMD_HOLD_BIT = 15;
    localparam int          CMD_SCAN_HI  = 14;
    localparam int          CMD_SCAN_LO  = 12;
    localparam int          CMD_WEN_BIT  = 11;
    localparam int          CMD_PAIR01_WETTING_ENABLE_BIT = 10;
    localparam int          CMD_CFG_HI   = 9;
    localparam int          CMD_CFG_LO   = 8;
    localparam int          CMD_MASK_HI  = 7;
    localparam int          FRAME_BITS   = 16;

    // Scan period codes that mean continuous monitoring
    localparam logic [2:0] SCAN_CONT_FIXED = 3'h6;
    localparam logic [2:0] SCAN_CONT       = 3'h7;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_OFF  = 2'b00,
        MODE_WAKE = 2'b01,
        MODE_NORM = 2'b10,
        MODE_SCAN = 2'b11
    } cmsc_mode_t;

    // Scan interval in milliseconds: 64 halved per code step
    function automatic logic [6:0] scan_period_ms(input logic [2:0] code);
        scan_period_ms = 7'h40 >> code;
    endfunction

endpackage

// ### verilog/cmsc_spi.sv
/*
 * Serial host port slave: 16-bit frames, MSB first, data taken on SCLK
 * rising and shifted out on SCLK falling, chip select active low.
 * Assumes the pins are asynchronous; each passes three flip-flops.
 */
`timescale 1ns/1ps
`default_nettype none

module cmsc_spi (
    // Clocking
    input  wire logic        clk,
    input  wire logic        ce,
    input  wire logic        rst,
    // Pins
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    // Core side
    input  wire logic [15:0] status,
    output logic [15:0]      wr_data,
    output logic             frame_done
);

    logic [2:0]  s1_r, s2_r, s3_r, filt_r, filt_nxt;
    logic [15:0] shin_r, shin_nxt, shout_r, shout_nxt, wr_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic        done_nxt;
    logic        cs_fall, cs_rise, sck_rise, sck_fall;

    // A pin change counts once the second and third stages agree
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
        end
    end

    assign cs_fall  = filt_r[0] & ~filt_nxt[0];
    assign cs_rise  = ~filt_r[0] & filt_nxt[0];
    assign sck_rise = ~filt_nxt[0] & ~filt_r[1] & filt_nxt[1];
    assign sck_fall = ~filt_nxt[0] & filt_r[1] & ~filt_nxt[1];

    // Shift engine; the status snapshot is taken at frame start
    always_comb begin
        shin_nxt  = shin_r;
        shout_nxt = shout_r;
        cnt_nxt   = cnt_r;
        wr_nxt    = wr_data;
        done_nxt  = 1'b0;
        if (cs_fall) begin
            shout_nxt = status;
            cnt_nxt   = 5'h00;
        end else if (sck_rise) begin
            shin_nxt = {shin_r[14:0], filt_nxt[2]};
            if (cnt_r != 5'h1F) begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end else if (sck_fall) begin
            shout_nxt = {shout_r[14:0], 1'b0};
        end else if (cs_rise && cnt_r == 5'(cmsc_pkg::FRAME_BITS)) begin
            wr_nxt   = shin_r; // Short or long frames are dropped
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r       <= 3'h5; // Idle levels: select high, SCLK low
            s2_r       <= 3'h5;
            s3_r       <= 3'h5;
            filt_r     <= 3'h5;
            shin_r     <= 16'h0000;
            shout_r    <= 16'h0000;
            cnt_r      <= 5'h00;
            wr_data    <= 16'h0000;
            frame_done <= 1'b0;
        end else if (ce) begin
            s1_r       <= {mosi, sclk, cs_n};
            s2_r       <= s1_r;
            s3_r       <= s2_r;
            filt_r     <= filt_nxt;
            shin_r     <= shin_nxt;
            shout_r    <= shout_nxt;
            cnt_r      <= cnt_nxt;
            wr_data    <= wr_nxt;
            frame_done <= done_nxt;
        end
    end

    assign miso    = shout_r[15];
    assign miso_oe = ~filt_r[0];

endmodule // cmsc_spi

`default_nettype wire

// ### verilog/cmsc_top.sv
/*
 * Contact monitor mode controller: command register, interrupt masking,
 * normal / scan / shutdown sequencing, sense and wetting gating, thermal
 * cut-offs. Assumes comparator results arrive as closed=1 levels from
 * outside the clock domain, and the serial host port drives the register.
 */
`timescale 1ns/1ps
`default_nettype none

module cmsc_top #(
    parameter int CHANNELS  = 8,
    parameter int MS_CYC    = cmsc_pkg::MS_CYC,
    parameter int POLL_CYC  = cmsc_pkg::POLL_WINDOW_CYC,
    parameter int WAKE_CYC  = cmsc_pkg::WAKE_DELAY_CYC
) (
    // Clocking and reset
    input  wire logic                CLK,
    input  wire logic                CE,
    input  wire logic                SYS_RST,
    // Serial host port
    input  wire logic                HOST_CS_N,
    input  wire logic                HOST_SCLK,
    input  wire logic                HOST_MOSI,
    output logic                     HOST_MISO,
    output logic                     HOST_MISO_OE,
    // Switch comparators and control pins
    input  wire logic [CHANNELS-1:0] SWITCH_INPUTS,
    input  wire logic                POWER_OFF_REQUEST_N,
    input  wire logic                TEMP_WARN,
    input  wire logic                TEMP_CRIT,
    // Interrupt
    output logic                     CHANGE_IRQ_N,
    // Analog controls
    output logic [CHANNELS-1:0]      SENSE_CONNECT,
    output logic [CHANNELS-1:0]      WETTING_ON,
    output logic [1:0]               SUPPLY_SIDE_SEL,
    output logic                     INPUTS_HIZ,
    output logic                     REGULATOR_EN,
    output logic                     FIXED_HYST,
    // Direct level outputs of inputs 0 and 1
    output logic                     DIRECT_LEVEL_OUT_0,
    output logic                     DIRECT_LEVEL_OUT_0_OE,
    output logic                     DIRECT_LEVEL_OUT_1,
    output logic                     DIRECT_LEVEL_OUT_1_OE
);

    localparam int NSYNC = CHANNELS + 3;
    localparam int MSW   = $clog2(MS_CYC + 1);
    localparam int PW    = $clog2(POLL_CYC + 1);
    localparam int WW    = $clog2(WAKE_CYC + 1);

    // Synchroniser stages: switches, power-off, warn, crit
    logic [NSYNC-1:0]    s1_r, s2_r, s3_r, filt_r, filt_nxt;
    // Mode and timing
    cmsc_pkg::cmsc_mode_t mode_r, mode_nxt;
    logic [15:0]         monitor_command_r, monitor_command_nxt;
    logic [MSW-1:0]      ms_cnt_r, ms_cnt_nxt;
    logic [6:0]          per_cnt_r, per_cnt_nxt;
    logic [PW-1:0]       win_cnt_r, win_cnt_nxt;
    logic                in_win_r, in_win_nxt;
    logic [WW-1:0]       wake_cnt_r, wake_cnt_nxt;
    logic                ms_tick, win_end;
    // Switch state
    logic [CHANNELS-1:0] switch_state_bits_r, switch_state_bits_nxt;
    logic [4:0]          closed_ms_r [CHANNELS], closed_ms_nxt [CHANNELS];
    logic                irq_r, irq_nxt;
    // Outputs
    logic [CHANNELS-1:0] sense_nxt, wet_nxt, wet_en;
    logic                hiz_nxt, reg_nxt, hyst_nxt, do_oe_nxt;
    // Serial port
    logic [15:0]         wr_data, status_word;
    logic                frame_done;
    // Command fields
    logic [2:0]          scan_code;
    logic                hold_mode, wen, pair01_wetting_enable;
    logic [7:0]          channel_irq_mask;
    logic                sw_live, power_off_request_n, twarn, tcrit;

    assign scan_code             = monitor_command_r[cmsc_pkg::CMD_SCAN_HI:cmsc_pkg::CMD_SCAN_LO];
    assign hold_mode             = monitor_command_r[cmsc_pkg::CMD_HOLD_BIT];
    assign wen                   = monitor_command_r[cmsc_pkg::CMD_WEN_BIT];
    assign pair01_wetting_enable = monitor_command_r[cmsc_pkg::CMD_PAIR01_WETTING_ENABLE_BIT];
    assign channel_irq_mask      = monitor_command_r[cmsc_pkg::CMD_MASK_HI:0];
    assign power_off_request_n   = filt_r[CHANNELS];
    assign twarn                 = filt_r[CHANNELS+1];
    assign tcrit                 = filt_r[CHANNELS+2];
    assign sw_live               = (mode_r == cmsc_pkg::MODE_NORM)
                                   || (mode_r == cmsc_pkg::MODE_SCAN);

    // Input status: closed in the high byte, input 7 at the top
    assign status_word = {switch_state_bits_r, twarn, 7'h00};

    cmsc_spi i_cmsc_spi (
        .clk        (CLK),
        .ce         (CE),
        .rst        (SYS_RST),
        .cs_n       (HOST_CS_N),
        .sclk       (HOST_SCLK),
        .mosi       (HOST_MOSI),
        .miso       (HOST_MISO),
        .miso_oe    (HOST_MISO_OE),
        .status     (status_word),
        .wr_data    (wr_data),
        .frame_done (frame_done)
    );

    // Pin filter: change taken once stages two and three agree
    always_comb begin
        for (int i = 0; i < NSYNC; i++) begin
            filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s1_r   <= NSYNC'(1) << CHANNELS; // Match idle levels: no false shutdown
            s2_r   <= NSYNC'(1) << CHANNELS;
            s3_r   <= NSYNC'(1) << CHANNELS;
            filt_r <= NSYNC'(1) << CHANNELS; // Power-off request idles high
        end else if (CE) begin
            s1_r   <= {TEMP_CRIT, TEMP_WARN, POWER_OFF_REQUEST_N, SWITCH_INPUTS};
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    assign ms_tick = (ms_cnt_r == MSW'(MS_CYC - 1));
    assign win_end = in_win_r && (win_cnt_r == '0);

    // Mode sequencing, command register and timebases
    always_comb begin
        mode_nxt            = mode_r;
        monitor_command_nxt = monitor_command_r;
        ms_cnt_nxt          = ms_tick ? '0 : ms_cnt_r + MSW'(1);
        per_cnt_nxt         = per_cnt_r;
        win_cnt_nxt         = win_cnt_r;
        in_win_nxt          = in_win_r;
        wake_cnt_nxt        = wake_cnt_r;
        case (mode_r)
            cmsc_pkg::MODE_OFF: begin
                monitor_command_nxt = cmsc_pkg::CMD_RESET;
                wake_cnt_nxt        = '0;
                if (power_off_request_n) begin
                    mode_nxt = cmsc_pkg::MODE_WAKE;
                end
            end
            cmsc_pkg::MODE_WAKE: begin
                wake_cnt_nxt = wake_cnt_r + WW'(1);
                if (wake_cnt_r == WW'(WAKE_CYC - 1)) begin
                    monitor_command_nxt = cmsc_pkg::CMD_RESET;
                    mode_nxt            = cmsc_pkg::MODE_SCAN;
                end
            end
            cmsc_pkg::MODE_NORM, cmsc_pkg::MODE_SCAN: begin
                if (frame_done) begin
                    monitor_command_nxt = wr_data;
                end
                if (monitor_command_nxt[cmsc_pkg::CMD_SCAN_HI:cmsc_pkg::CMD_SCAN_HI-1]
                        == 2'h3) begin
                    mode_nxt = cmsc_pkg::MODE_NORM;
                end else begin
                    mode_nxt = cmsc_pkg::MODE_SCAN;
                end
            end
            default: mode_nxt = cmsc_pkg::MODE_OFF;
        endcase
        if (!power_off_request_n) begin
            mode_nxt = cmsc_pkg::MODE_OFF;
        end
        // Scan timing: one poll window per programmed period
        if (mode_r != cmsc_pkg::MODE_SCAN) begin
            per_cnt_nxt = '0;
            in_win_nxt  = 1'b0;
            win_cnt_nxt = '0;
        end else begin
            if (ms_tick) begin
                if (per_cnt_r + 7'h01 >= cmsc_pkg::scan_period_ms(scan_code)) begin
                    per_cnt_nxt = '0;
                    in_win_nxt  = 1'b1;
                    win_cnt_nxt = PW'(POLL_CYC - 1);
                end else begin
                    per_cnt_nxt = per_cnt_r + 7'h01;
                end
            end
            if (in_win_r && !(ms_tick && in_win_nxt && win_cnt_r == '0)) begin
                if (win_cnt_r == '0) begin
                    in_win_nxt = 1'b0;
                end else begin
                    win_cnt_nxt = win_cnt_r - PW'(1);
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mode_r            <= cmsc_pkg::MODE_SCAN;
            monitor_command_r <= cmsc_pkg::CMD_RESET;
            ms_cnt_r          <= '0;
            per_cnt_r         <= '0;
            win_cnt_r         <= '0;
            in_win_r          <= 1'b0;
            wake_cnt_r        <= '0;
        end else if (CE) begin
            mode_r            <= mode_nxt;
            monitor_command_r <= monitor_command_nxt;
            ms_cnt_r          <= ms_cnt_nxt;
            per_cnt_r         <= per_cnt_nxt;
            win_cnt_r         <= win_cnt_nxt;
            in_win_r          <= in_win_nxt;
            wake_cnt_r        <= wake_cnt_nxt;
        end
    end

    // Debounced state, closure age and change interrupt
    always_comb begin
        logic [CHANNELS-1:0] take, chg;
        take  = '0;
        chg   = '0;
        if (mode_r == cmsc_pkg::MODE_NORM) begin
            take = '1;
        end else if (mode_r == cmsc_pkg::MODE_SCAN && win_end) begin
            take = '1; // Sample at the close of the poll window
        end
        take[1:0] = take[1:0] & {2{pair01_wetting_enable}};
        switch_state_bits_nxt = sw_live
            ? (take & filt_r[CHANNELS-1:0]) | (~take & switch_state_bits_r) : '0;
        for (int i = 0; i < CHANNELS; i++) begin
            closed_ms_nxt[i] = closed_ms_r[i];
            if (!switch_state_bits_nxt[i]) begin
                closed_ms_nxt[i] = 5'h00;
            end else if (ms_tick && closed_ms_r[i] != 5'(cmsc_pkg::WET_PULSE_MS)) begin
                closed_ms_nxt[i] = closed_ms_r[i] + 5'h01;
            end
        end
        chg = (switch_state_bits_nxt ^ switch_state_bits_r) & take
              & ~channel_irq_mask;
        // A new change wins over the release by a status read
        irq_nxt = sw_live && ((irq_r && !frame_done) || (|chg));
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            switch_state_bits_r <= '0;
            irq_r               <= 1'b0;
            for (int i = 0; i < CHANNELS; i++) begin
                closed_ms_r[i] <= 5'h00;
            end
        end else if (CE) begin
            switch_state_bits_r <= switch_state_bits_nxt;
            irq_r               <= irq_nxt;
            closed_ms_r         <= closed_ms_nxt;
        end
    end

    // Wetting permitted per channel: inputs 0/1 need both enables
    assign wet_en = {{(CHANNELS-2){wen}}, {2{wen & pair01_wetting_enable}}};

    // Analog control levels, registered
    always_comb begin
        sense_nxt = '0;
        wet_nxt   = '0;
        hiz_nxt   = 1'b1;
        reg_nxt   = ~tcrit;
        hyst_nxt  = 1'b0;
        do_oe_nxt = 1'b0;
        if (mode_r == cmsc_pkg::MODE_OFF) begin
            reg_nxt = 1'b0;
        end else if (sw_live) begin
            hiz_nxt = 1'b0;
            if (mode_r == cmsc_pkg::MODE_NORM || in_win_r) begin
                sense_nxt = {{(CHANNELS-2){1'b1}}, {2{pair01_wetting_enable}}};
            end
            for (int i = 0; i < CHANNELS; i++) begin
                wet_nxt[i] = wet_en[i] && switch_state_bits_r[i] && !twarn
                    && (mode_r == cmsc_pkg::MODE_NORM || in_win_r)
                    && (hold_mode || closed_ms_r[i] != 5'(cmsc_pkg::WET_PULSE_MS));
            end
            hyst_nxt  = (mode_r == cmsc_pkg::MODE_NORM)
                        && (scan_code == cmsc_pkg::SCAN_CONT_FIXED);
            do_oe_nxt = (mode_r == cmsc_pkg::MODE_NORM) && !pair01_wetting_enable;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            SENSE_CONNECT         <= '0;
            WETTING_ON            <= '0;
            SUPPLY_SIDE_SEL       <= 2'h0;
            INPUTS_HIZ            <= 1'b0;
            REGULATOR_EN          <= 1'b1;
            FIXED_HYST            <= 1'b0;
            DIRECT_LEVEL_OUT_0    <= 1'b0;
            DIRECT_LEVEL_OUT_0_OE <= 1'b0;
            DIRECT_LEVEL_OUT_1    <= 1'b0;
            DIRECT_LEVEL_OUT_1_OE <= 1'b0;
        end else if (CE) begin
            SENSE_CONNECT         <= sense_nxt;
            WETTING_ON            <= wet_nxt;
            SUPPLY_SIDE_SEL       <= monitor_command_r[cmsc_pkg::CMD_CFG_HI:cmsc_pkg::CMD_CFG_LO];
            INPUTS_HIZ            <= hiz_nxt;
            REGULATOR_EN          <= reg_nxt;
            FIXED_HYST            <= hyst_nxt;
            DIRECT_LEVEL_OUT_0    <= filt_r[0];
            DIRECT_LEVEL_OUT_0_OE <= do_oe_nxt;
            DIRECT_LEVEL_OUT_1    <= filt_r[1];
            DIRECT_LEVEL_OUT_1_OE <= do_oe_nxt;
        end
    end

    assign CHANGE_IRQ_N = ~irq_r; // Interrupt pin is active low

endmodule // cmsc_top

`default_nettype wire

// ### bench/cmsc_top_asserts.sv
/* Port checker for cmsc_top: shutdown, thermal, direct-output and interrupt hold.
   Assumes CE is held high; bound to every cmsc_top instance. */
`timescale 1ns/1ps
`default_nettype none

module cmsc_top_asserts (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       SYS_RST,
    // Watched inputs
    input wire logic       HOST_CS_N,
    input wire logic       POWER_OFF_REQUEST_N,
    input wire logic       TEMP_WARN,
    input wire logic       TEMP_CRIT,
    // Watched outputs
    input wire logic       CHANGE_IRQ_N,
    input wire logic [7:0] SENSE_CONNECT,
    input wire logic [7:0] WETTING_ON,
    input wire logic       INPUTS_HIZ,
    input wire logic       REGULATOR_EN,
    input wire logic       DIRECT_LEVEL_OUT_0_OE,
    input wire logic       DIRECT_LEVEL_OUT_1_OE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    logic [3:0] quiet_r;
    logic [3:0] quiet_nxt;

    // Cycles with no frame and no power-off; pin filters need a few first
    always_comb begin
        quiet_nxt = (!HOST_CS_N || !POWER_OFF_REQUEST_N) ? 4'h0
                    : quiet_r + {3'h0, quiet_r != 4'hF};
    end
    always_ff @(posedge CLK) begin
        quiet_r <= SYS_RST ? 4'h0 : quiet_nxt;
    end

    // Shutdown shows at the pins only after filter, mode and output registers
    chk_off_regulator: assert property (
        (!POWER_OFF_REQUEST_N) [*7] |-> !REGULATOR_EN && INPUTS_HIZ)
        else $error("regulator or inputs active in shutdown");
    chk_off_all_quiet: assert property (
        (!POWER_OFF_REQUEST_N) [*7] |->
        CHANGE_IRQ_N && SENSE_CONNECT == 8'h00 && WETTING_ON == 8'h00)
        else $error("activity while shut down");
    chk_warn_no_wet: assert property (TEMP_WARN [*6] |-> WETTING_ON == 8'h00)
        else $error("wetting on during thermal warning");
    chk_warn_reg_on: assert property (
        (TEMP_WARN && !TEMP_CRIT && POWER_OFF_REQUEST_N) [*8] |-> REGULATOR_EN)
        else $error("regulator off on warning alone");
    chk_crit_reg_off: assert property (TEMP_CRIT [*6] |-> !REGULATOR_EN)
        else $error("regulator on at critical temperature");
    chk_wet_sensed: assert property ((WETTING_ON & ~SENSE_CONNECT) == 8'h00)
        else $error("wetting without sense connected");
    chk_direct_pair: assert property (DIRECT_LEVEL_OUT_0_OE |->
        DIRECT_LEVEL_OUT_1_OE && SENSE_CONNECT[1:0] == 2'b00 && !INPUTS_HIZ)
        else $error("direct outputs driven out of normal pass-through");
    chk_irq_held: assert property (!CHANGE_IRQ_N && quiet_r > 4'h8 |=> !CHANGE_IRQ_N)
        else $error("interrupt released without a frame");
endmodule // cmsc_top_asserts

bind cmsc_top cmsc_top_asserts i_cmsc_top_asserts (.CLK, .SYS_RST, .HOST_CS_N,
    .POWER_OFF_REQUEST_N, .TEMP_WARN, .TEMP_CRIT, .CHANGE_IRQ_N, .SENSE_CONNECT, .WETTING_ON,
    .INPUTS_HIZ, .REGULATOR_EN, .DIRECT_LEVEL_OUT_0_OE, .DIRECT_LEVEL_OUT_1_OE);

`default_nettype wire

// ### bench/cmsc_switch_model.sv
/* Remote switch bank as seen through the comparators.
   Assumes the bench sets the closed pattern; floated inputs read noise. */
`timescale 1ns/1ps
`default_nettype none

module cmsc_switch_model (
    // Clock and bench control
    input  wire logic       clk,
    input  wire logic [7:0] closed,
    input  wire logic       hiz,
    // Comparator results, 1 = closed
    output logic [7:0]      level
);
    logic ph_r = 1'b0;

    // Floating inputs give no stable reading, so the pattern flips each cycle
    always @(posedge clk) ph_r <= ~ph_r;
    assign level = hiz ? {8{ph_r}} : closed;
endmodule // cmsc_switch_model

`default_nettype wire

// ### bench/cmsc_top_tb.sv
/* Self-checking bench for cmsc_top: serial frames, scan timing, modes.
   Assumes shortened counts of 20 cycles per millisecond. */
`timescale 1ns/1ps
`default_nettype none

module cmsc_top_tb;
    localparam int MS = 20;
    localparam int POLL = 5;
    localparam int WAKE = 10;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cs_n = 1'b1;
    logic        sclk = 1'b0;
    logic        mosi = 1'b0;
    logic        pwr_n = 1'b1;
    logic        warn = 1'b0;
    logic        crit = 1'b0;
    logic [7:0]  closed = 8'h00;
    logic [7:0]  sw, sense, wet;
    logic        miso, irq_n, hiz, reg_en, hyst, d0, d0_oe, miso_oe, d1, d1_oe;
    logic [1:0]  side;
    logic [15:0] cmd, rd;
    int          err_total = 0;
    int          total_checks = 0;
    int          n;

    cmsc_switch_model i_cmsc_switch_model (.clk(clk), .closed(closed), .hiz(hiz), .level(sw));
    cmsc_top #(.MS_CYC(MS), .POLL_CYC(POLL), .WAKE_CYC(WAKE)) i_cmsc_top (
        .CLK(clk), .CE(1'b1), .SYS_RST(rst), .HOST_CS_N(cs_n), .HOST_SCLK(sclk),
        .HOST_MOSI(mosi), .HOST_MISO(miso), .HOST_MISO_OE(miso_oe), .SWITCH_INPUTS(sw),
        .POWER_OFF_REQUEST_N(pwr_n), .TEMP_WARN(warn), .TEMP_CRIT(crit),
        .CHANGE_IRQ_N(irq_n), .SENSE_CONNECT(sense), .WETTING_ON(wet),
        .SUPPLY_SIDE_SEL(side), .INPUTS_HIZ(hiz), .REGULATOR_EN(reg_en), .FIXED_HYST(hyst),
        .DIRECT_LEVEL_OUT_0(d0), .DIRECT_LEVEL_OUT_0_OE(d0_oe),
        .DIRECT_LEVEL_OUT_1(d1), .DIRECT_LEVEL_OUT_1_OE(d1_oe));

    always #2 clk = ~clk;

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic test_done;
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One frame writes cmd and captures status; 6 cycles a half bit outlasts the filter
    task automatic xfer;
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = cmd[i];
            cyc(6);
            rd[i] = miso;
            if (i == 15) chk(miso_oe, 1'b1);
            sclk = 1'b1;
            cyc(6);
            sclk = 1'b0;
        end
        cyc(6);
        cs_n = 1'b1;
        cyc(12);
        chk(miso_oe, 1'b0);
    endtask
    // Bounded wait on the top sense line; n returns the cycles spent
    task automatic wait_s7(input logic v, input int lim);
        n = 0;
        while (sense[7] !== v && n < lim) begin
            cyc(1);
            n++;
        end
        if (n >= lim) begin
            err_total++;
            test_done();
        end
    endtask
    // Window length, connected set and start-to-start period of the scan
    task automatic scan_period(input int ms, input logic [7:0] exp_s);
        wait_s7(1'b1, 64 * MS + 20);
        chk(sense, exp_s);
        wait_s7(1'b0, POLL + 2);
        chk(16'(n), 16'(POLL));
        wait_s7(1'b1, 64 * MS);
        chk(16'(n + POLL), 16'(ms * MS));
    endtask

    initial begin
        cyc(5);
        rst = 1'b0;
        cyc(4);
        chk(d0_oe, 1'b0);
        scan_period(64, 8'hFC);
        // Every finite code, pair enabled so all eight sense lines join the window
        for (int c = 0; c < 6; c++) begin
            cmd = {1'b0, 3'(c), 4'b0100, 8'hFF};
            xfer;
            scan_period(64 >> c, 8'hFF);
        end
        cmd = 16'h7400;
        xfer;
        chk(sense, 8'hFF);
        chk(hyst, 1'b0);
        cmd = 16'h6400;
        xfer;
        chk(hyst, 1'b1);
        // Each channel alone unmasked; its neighbour masked toggles first
        for (int c = 0; c < 8; c++) begin
            cmd = {8'h74, 8'hFF ^ (8'h01 << c)};
            xfer;
            closed[(c + 1) % 8] = ~closed[(c + 1) % 8];
            cyc(10);
            chk(irq_n, 1'b1);
            closed[c] = ~closed[c];
            cyc(10);
            chk(irq_n, 1'b0);
            xfer;
            chk(rd, {closed, 8'h00});
            chk(irq_n, 1'b1);
        end
        cmd = 16'h7000;
        xfer;
        closed[1:0] = ~closed[1:0];
        cyc(10);
        chk(irq_n, 1'b1);
        chk({d1_oe, d1, d0_oe, d0}, {1'b1, closed[1], 1'b1, closed[0]});
        chk(sense, 8'hFC);
        closed = 8'hFF;
        cmd = 16'hFC00;
        xfer;
        chk(wet, 8'hFF);
        warn = 1'b1;
        cyc(10);
        chk(wet, 8'h00);
        chk(reg_en, 1'b1);
        crit = 1'b1;
        cyc(10);
        chk(reg_en, 1'b0);
        warn = 1'b0;
        crit = 1'b0;
        cmd = 16'h7F00;
        closed = 8'h00;
        xfer;
        closed = 8'hFF;
        cyc(10);
        chk(wet, 8'hFF);
        cyc(20 * MS);
        chk(wet, 8'h00);
        chk(side, 2'h3);
        pwr_n = 1'b0;
        cyc(10);
        chk(reg_en, 1'b0);
        chk(hiz, 1'b1);
        pwr_n = 1'b1;
        cyc(WAKE + 10);
        chk(hiz, 1'b0);
        chk(sense, 8'h00);
        chk(side, 2'h0);
        chk({d1_oe, d0_oe}, 2'b00);
        scan_period(64, 8'hFC);
        test_done();
    end
endmodule // cmsc_top_tb

`default_nettype wire
